/* File: hw/lmp_device.sv */
// Device end: serial register port and presettable error counters
// Summary of operation
// - Command byte precedes every register data byte
// - Bit0 read/write, bits1-4 address, bit7 burst
// - Host sends zeros in bits 5 and 6
// - Everything shifts least significant bit first
// - Chip select high aborts, idles, floats output
// - Input sampled on rising serial clock edge
// - Output changes on falling edge only
// - Write captures next eight bits; output floats
// - Read shifts register on next eight falls
// - Burst at address zero walks all registers
// - Burst read leaves status bits latched
// - Port needs no line clock; clears do
// - Counters preset, count up, flag saturation
// - Auto reset clears counters after any read
// - Reads leave counts; no event lost
// - Violation counter skips substitution codewords
// - Excess-zero mode counts 8 or 16 zeros
// - Violation counter ignores sync loss, saturates
// - Host writes violation low before high
// - CRC counter only in extended mode
// - Out-of-frame counter pauses, saturates, flags
// - Frame error counter selects pattern by mode
// - Status latches; non-burst read clears it
// - Eleven registers at fixed addresses
`timescale 1ns/10ps
module lmp_device
	import lmp_pkg::*;
(
	// Clock and reset
	input  wire logic       REF_CLK_I,
	input  wire logic       RESET_N_I,
	// Serial port
	lmp_port_if.device      PORT,
	// Line clock and framer strobes, taken at line clock rise
	input  wire logic       LINE_CLK_I,
	input  wire logic       SYNC_LOST_I,
	input  wire logic       VIOL_I,
	input  wire logic       CODEWORD_I,
	input  wire logic       ZERO8_I,
	input  wire logic       ZERO16_I,
	input  wire logic       CRC_ERR_I,
	input  wire logic       OOF_EVENT_I,
	input  wire logic       FT_ERR_I,
	input  wire logic       FS_ERR_I,
	input  wire logic       FPS_ERR_I,
	input  wire logic [7:0] STATUS_ONE_COND_I,
	input  wire logic [7:0] STATUS_TWO_COND_I,
	// Alarm and control
	output logic            ALARM_INT_O,
	output logic [7:0]      LINE_CONTROL_ONE_O,
	output logic [7:0]      LINE_CONTROL_TWO_O
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		lmp_dev_fsm_type state;
		logic [2:0]      bit_cnt;
		logic [7:0]      sh;
		logic [7:0]      tx;
		logic [3:0]      addr;
		logic            burst;
		logic            rd_done;
		logic            sclk_d;
		logic            line_d;
		logic            serial_out;
		logic            sdo_oe;
		logic [15:0]     viol;
		logic [7:0]      viol_hold;
		logic [7:0]      crc;
		logic [7:0]      out_of_frame_event;
		logic [7:0]      fe;
		logic [7:0]      st1;
		logic [7:0]      st2;
		logic [7:0]      mask1;
		logic [7:0]      mask2;
		logic [7:0]      ctl1;
		logic [7:0]      ctl2;
		logic            clr_st1;
		logic            clr_st2;
		logic            clr_cnt;
		logic            irq;
	} lmp_dev_state_type;

	lmp_dev_state_type r_ff;
	lmp_dev_state_type nxt_r;
	logic              cs_n_s;
	logic              sclk_s;
	logic              sdi_s;
	logic              line_s;

	function automatic logic [16:0] sat_inc(input logic [15:0] v, input logic [15:0] max);
		sat_inc = (v == max) ? {1'b1, v} : {1'b0, v + 16'h0001};
	endfunction : sat_inc

	// Serial data is a snapshot; counting goes on in the live counters
	function automatic logic [7:0] rd(input lmp_dev_state_type s, input logic [3:0] a);
		case (a)
			RA_VIOL_LO: rd = s.viol[7:0];
			RA_VIOL_HI: rd = s.viol[15:8];
			RA_CRC:     rd = s.crc;
			RA_OOF:     rd = s.out_of_frame_event;
			RA_FE:      rd = s.fe;
			RA_ST1:     rd = s.st1;
			RA_MASK1:   rd = s.mask1;
			RA_ST2:     rd = s.st2;
			RA_MASK2:   rd = s.mask2;
			RA_CTL1:    rd = s.ctl1;
			RA_CTL2:    rd = s.ctl2;
			default:    rd = REG_RST;
		endcase
	endfunction : rd

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	lmp_sync #(.WIDTH(4)) u_sync
	(
		.clk_i     (REF_CLK_I),
		.reset_n_i (RESET_N_I),
		.async_i   ({PORT.cs_n, PORT.sclk, PORT.serial_in, LINE_CLK_I}),
		.sync_o    ({cs_n_s, sclk_s, sdi_s, line_s})
	);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		logic        rise;
		logic        fall;
		logic        tick;
		logic        ext;
		logic        ev_v;
		logic        ev_c;
		logic        ev_o;
		logic        ev_f;
		logic [16:0] inc;
		logic [7:0]  set2;
		logic [7:0]  byte_in;
		logic [3:0]  a_next;
		logic [3:0]  a_cmd;
		rise    = sclk_s & ~r_ff.sclk_d;
		fall    = ~sclk_s & r_ff.sclk_d;
		tick    = line_s & ~r_ff.line_d;
		ext     = r_ff.ctl2[C2_EXT];
		ev_v    = r_ff.ctl2[C2_EXZ] ? (r_ff.ctl2[C2_ZSUB] ? ZERO8_I : ZERO16_I)
			: (VIOL_I & ~(r_ff.ctl2[C2_ZSUB] & CODEWORD_I));
		ev_c    = CRC_ERR_I & ~SYNC_LOST_I;
		ev_o    = OOF_EVENT_I & ~SYNC_LOST_I;
		ev_f    = ~SYNC_LOST_I & (ext ? FPS_ERR_I
			: (FT_ERR_I | (r_ff.ctl1[C1_FS_EN] & FS_ERR_I)));
		inc     = '0;
		set2    = STATUS_TWO_COND_I & S2_COND_MASK;
		byte_in = {sdi_s, r_ff.sh[7:1]};
		a_next  = (r_ff.addr == RA_LAST) ? RA_VIOL_LO : r_ff.addr + 4'h1;
		a_cmd   = byte_in[CB_ADDR_HI:CB_ADDR_LO];
		nxt_r   = r_ff;
		nxt_r.sclk_d = sclk_s;
		nxt_r.line_d = line_s;

		// --------------------------------------------------------
		// Line side: counting and status clears need the line clock
		// --------------------------------------------------------
		if (tick)
		begin
			if (r_ff.clr_cnt)
			begin
				nxt_r.viol = '0;
				nxt_r.crc  = REG_RST;
				nxt_r.out_of_frame_event  = REG_RST;
				nxt_r.fe   = REG_RST;
			end
			// A clear and an event on the same tick give a count of one
			if (ev_v)
			begin
				inc = sat_inc(nxt_r.viol, VIOL_MAX);
				nxt_r.viol = inc[15:0];
				set2[S2_VIOL_SAT] = inc[16];
			end
			if (!ext)
				nxt_r.crc = REG_RST;
			else if (ev_c)
			begin
				inc = sat_inc({8'h00, nxt_r.crc}, CNT8_MAX);
				nxt_r.crc = inc[7:0];
				set2[S2_CRC_SAT] = inc[16];
			end
			if (ev_o)
			begin
				inc = sat_inc({8'h00, nxt_r.out_of_frame_event}, CNT8_MAX);
				nxt_r.out_of_frame_event = inc[7:0];
				set2[S2_OOF_SAT] = inc[16];
			end
			if (ev_f)
			begin
				inc = sat_inc({8'h00, nxt_r.fe}, CNT8_MAX);
				nxt_r.fe = inc[7:0];
				set2[S2_FE_SAT] = inc[16];
			end
			// Set wins over a pending clear; live conditions keep their bit
			nxt_r.st1     = (r_ff.clr_st1 ? REG_RST : r_ff.st1) | STATUS_ONE_COND_I;
			nxt_r.st2     = (r_ff.clr_st2 ? REG_RST : r_ff.st2) | set2;
			nxt_r.clr_st1 = 1'b0;
			nxt_r.clr_st2 = 1'b0;
			nxt_r.clr_cnt = 1'b0;
		end

		// --------------------------------------------------------
		// Serial port
		// --------------------------------------------------------
		if (cs_n_s)
		begin
			if (r_ff.rd_done && r_ff.ctl1[C1_AUTO_RST])
				nxt_r.clr_cnt = 1'b1;
			nxt_r.state   = DEV_IDLE;
			nxt_r.sdo_oe  = 1'b0;
			nxt_r.bit_cnt = BIT_FIRST;
			nxt_r.rd_done = 1'b0;
		end
		else
		begin
			case (r_ff.state)
				DEV_IDLE:
				begin
					nxt_r.state   = DEV_CMD;
					nxt_r.bit_cnt = BIT_FIRST;
				end
				DEV_CMD:
				begin
					if (rise)
					begin
						nxt_r.sh      = byte_in;
						nxt_r.bit_cnt = r_ff.bit_cnt + 3'h1;
						if (r_ff.bit_cnt == BIT_LAST)
						begin
							nxt_r.addr  = a_cmd;
							nxt_r.burst = byte_in[CB_BURST] && (a_cmd == RA_VIOL_LO);
							if (byte_in[CB_RW])
							begin
								nxt_r.state = DEV_READ;
								nxt_r.tx    = rd(r_ff, a_cmd);
							end
							else
								nxt_r.state = DEV_WRITE;
						end
					end
				end
				DEV_WRITE:
				begin
					if (rise)
					begin
						nxt_r.sh      = byte_in;
						nxt_r.bit_cnt = r_ff.bit_cnt + 3'h1;
						if (r_ff.bit_cnt == BIT_LAST)
						begin
							case (r_ff.addr)
								RA_VIOL_LO: nxt_r.viol_hold = byte_in;
								RA_VIOL_HI: nxt_r.viol      = {byte_in, r_ff.viol_hold};
								RA_CRC:     nxt_r.crc       = byte_in;
								RA_OOF:     nxt_r.out_of_frame_event       = byte_in;
								RA_FE:      nxt_r.fe        = byte_in;
								RA_MASK1:   nxt_r.mask1     = byte_in;
								RA_MASK2:   nxt_r.mask2     = byte_in;
								RA_CTL1:    nxt_r.ctl1      = byte_in;
								RA_CTL2:    nxt_r.ctl2      = byte_in;
								default:    nxt_r.viol_hold = r_ff.viol_hold;
							endcase
							if (r_ff.burst)
								nxt_r.addr = a_next;
							else
								nxt_r.state = DEV_HALT;
						end
					end
				end
				DEV_READ:
				begin
					if (fall)
					begin
						nxt_r.serial_out    = r_ff.tx[0];
						nxt_r.tx     = {1'b0, r_ff.tx[7:1]};
						nxt_r.sdo_oe = 1'b1;
					end
					if (rise)
					begin
						nxt_r.bit_cnt = r_ff.bit_cnt + 3'h1;
						if (r_ff.bit_cnt == BIT_LAST)
						begin
							nxt_r.rd_done = 1'b1;
							// Burst reads never disturb the latched status
							if (!r_ff.burst && (r_ff.addr == RA_ST1))
								nxt_r.clr_st1 = 1'b1;
							if (!r_ff.burst && (r_ff.addr == RA_ST2))
								nxt_r.clr_st2 = 1'b1;
							if (r_ff.burst)
							begin
								nxt_r.addr = a_next;
								nxt_r.tx   = rd(r_ff, a_next);
							end
							else
								nxt_r.state = DEV_HALT;
						end
					end
				end
				DEV_HALT:
				begin
					// Last bit stays until the next fall, then the pin floats
					if (fall)
						nxt_r.sdo_oe = 1'b0;
				end
				default:
					nxt_r.state = DEV_IDLE;
			endcase
		end
		nxt_r.irq = |(r_ff.st1 & r_ff.mask1) | |(r_ff.st2 & r_ff.mask2);
	end

	always_ff @(posedge REF_CLK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
			r_ff <= '0;
		else
			r_ff <= nxt_r;
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign PORT.serial_out           = r_ff.serial_out;
	assign PORT.sdo_oe        = r_ff.sdo_oe;
	assign ALARM_INT_O        = r_ff.irq;
	assign LINE_CONTROL_ONE_O = r_ff.ctl1;
	assign LINE_CONTROL_TWO_O = r_ff.ctl2;
endmodule : lmp_device

/* File: hw/lmp_pkg.sv */
// Constants and types shared by both ends of the line monitor serial port
package lmp_pkg;
	// ------------------------------------------------------------
	// Register indices
	// ------------------------------------------------------------
	localparam logic [3:0]  RA_VIOL_LO      = 4'h0;
	localparam logic [3:0]  RA_VIOL_HI      = 4'h1;
	localparam logic [3:0]  RA_CRC          = 4'h2;
	localparam logic [3:0]  RA_OOF          = 4'h3;
	localparam logic [3:0]  RA_FE           = 4'h4;
	localparam logic [3:0]  RA_ST1          = 4'h5;
	localparam logic [3:0]  RA_MASK1        = 4'h6;
	localparam logic [3:0]  RA_ST2          = 4'h7;
	localparam logic [3:0]  RA_MASK2        = 4'h8;
	localparam logic [3:0]  RA_CTL1         = 4'h9;
	localparam logic [3:0]  RA_CTL2         = 4'ha;
	localparam logic [3:0]  RA_LAST         = RA_CTL2;
	localparam logic [7:0]  REG_RST         = 8'h00;
	// ------------------------------------------------------------
	// Command byte and register fields
	// ------------------------------------------------------------
	localparam int          CB_RW           = 0;
	localparam int          CB_ADDR_LO      = 1;
	localparam int          CB_ADDR_HI      = 4;
	localparam int          CB_BURST        = 7;
	localparam logic [1:0]  CB_RESERVED     = 2'h0;
	localparam int          C1_FS_EN        = 3;
	localparam int          C1_AUTO_RST     = 4;
	localparam int          C2_ZSUB         = 2;
	localparam int          C2_EXT          = 4;
	localparam int          C2_EXZ          = 5;
	localparam int          S2_VIOL_SAT     = 0;
	localparam int          S2_CRC_SAT      = 1;
	localparam int          S2_OOF_SAT      = 2;
	localparam int          S2_FE_SAT       = 3;
	localparam logic [7:0]  S2_COND_MASK    = 8'hf0;
	localparam logic [15:0] VIOL_MAX        = 16'hffff;
	localparam logic [15:0] CNT8_MAX        = 16'h00ff;
	// ------------------------------------------------------------
	// Bit counting and timing
	// ------------------------------------------------------------
	localparam logic [2:0]  BIT_FIRST       = 3'h0;
	localparam logic [2:0]  BIT_LAST        = 3'h7;
	localparam logic [6:0]  PER_FIRST_RX    = 7'h09;
	localparam logic [6:0]  PER_FIRST_RDATA = 7'h10;
	localparam int          REF_PERIOD_NS   = 8;
	localparam int          SCLK_PERIOD_NS  = 80;
	localparam int          SCLK_HALF_CYC   = SCLK_PERIOD_NS / (2 * REF_PERIOD_NS);
	localparam int          DIV_W           = 8;
	// ------------------------------------------------------------
	// State machines
	// ------------------------------------------------------------
	typedef enum logic [2:0] {DEV_IDLE, DEV_CMD, DEV_WRITE, DEV_READ, DEV_HALT} lmp_dev_fsm_type;
	typedef enum logic [1:0] {HOST_IDLE, HOST_RUN, HOST_TAIL} lmp_host_fsm_type;
endpackage : lmp_pkg

/* File: hw/lmp_port_if.sv */
// Serial port wires between the host end and the device end
`timescale 1ns/10ps
interface lmp_port_if;
	logic cs_n;
	logic sclk;
	logic serial_in;
	logic serial_out;
	logic sdo_oe;
	logic sdo_line;

	// Floated output reads high, as with a pull-up on the board
	assign sdo_line = sdo_oe ? serial_out : 1'b1;

	modport device (input cs_n, input sclk, input serial_in, output serial_out, output sdo_oe);
	modport host   (output cs_n, output sclk, output serial_in, input sdo_line);
endinterface : lmp_port_if

/* File: hw/lmp_sync.sv */
// Two-stage synchroniser for inputs from outside the clock domain
`timescale 1ns/10ps
module lmp_sync
	import lmp_pkg::*;
#(
	parameter int WIDTH = 1
)
(
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             reset_n_i,
	// Data
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} lmp_sync_state_type;

	lmp_sync_state_type r_ff;
	lmp_sync_state_type nxt_r;

	// First stage feeds only the second stage
	always_comb
	begin
		nxt_r.meta   = async_i;
		nxt_r.stable = r_ff.meta;
	end

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			r_ff <= '0;
		else
			r_ff <= nxt_r;
	end

	assign sync_o = r_ff.stable;
endmodule : lmp_sync

/* File: hw/lmp_host.sv */
// Host end: drives chip select and serial clock, shifts command and data
`timescale 1ns/10ps
module lmp_host
	import lmp_pkg::*;
#(
	parameter int HALF_CYC = SCLK_HALF_CYC
)
(
	// Clock and reset
	input  wire logic       REF_CLK_I,
	input  wire logic       RESET_N_I,
	// Serial port
	lmp_port_if.host        PORT,
	// Request
	input  wire logic       START_I,
	input  wire logic       CMD_READ_I,
	input  wire logic [3:0] CMD_ADDR_I,
	input  wire logic       CMD_BURST_I,
	input  wire logic [3:0] BYTE_COUNT_I,
	input  wire logic [7:0] WDATA_I,
	// Answer
	output logic            WDATA_TAKE_O,
	output logic [7:0]      RDATA_O,
	output logic            RDATA_VALID_O,
	output logic            BUSY_O,
	output logic            DONE_O
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		lmp_host_fsm_type state;
		logic [DIV_W-1:0] div;
		logic [6:0]       per;
		logic [6:0]       total;
		logic             read;
		logic [7:0]       tx;
		logic [7:0]       rx;
		logic             cs_n;
		logic             sclk;
		logic             serial_in;
		logic             take;
		logic [7:0]       rdata;
		logic             rvalid;
		logic             busy;
		logic             done;
	} lmp_host_state_type;

	localparam logic [DIV_W-1:0] DIV_END = DIV_W'(HALF_CYC - 1);

	lmp_host_state_type r_ff;
	lmp_host_state_type nxt_r;
	logic               sdo_s;

	lmp_sync #(.WIDTH(1)) u_sync
	(
		.clk_i     (REF_CLK_I),
		.reset_n_i (RESET_N_I),
		.async_i   (PORT.sdo_line),
		.sync_o    (sdo_s)
	);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		logic [7:0] src;
		logic [7:0] rx_new;
		src          = r_ff.tx;
		rx_new       = {sdo_s, r_ff.rx[7:1]};
		nxt_r        = r_ff;
		nxt_r.take   = 1'b0;
		nxt_r.rvalid = 1'b0;
		nxt_r.done   = 1'b0;
		case (r_ff.state)
			HOST_IDLE:
			begin
				nxt_r.cs_n = 1'b1;
				nxt_r.sclk = 1'b1;
				if (START_I)
				begin
					// Reserved command bits always go out as zero
					nxt_r.tx    = {CMD_BURST_I, CB_RESERVED, CMD_ADDR_I, CMD_READ_I};
					nxt_r.total = 7'({BYTE_COUNT_I + 4'h1, BIT_FIRST});
					nxt_r.per   = '0;
					nxt_r.div   = '0;
					nxt_r.read  = CMD_READ_I;
					nxt_r.cs_n  = 1'b0;
					nxt_r.busy  = 1'b1;
					nxt_r.state = HOST_RUN;
				end
			end
			HOST_RUN:
			begin
				if (r_ff.div == DIV_END)
				begin
					nxt_r.div = '0;
					if (r_ff.sclk)
					begin
						// Falling edge: sample the bit the device showed last period
						nxt_r.sclk = 1'b0;
						if (r_ff.read && (r_ff.per >= PER_FIRST_RX))
							nxt_r.rx = rx_new;
						if (r_ff.read && (r_ff.per >= PER_FIRST_RDATA)
							&& (r_ff.per[2:0] == BIT_FIRST))
						begin
							nxt_r.rdata  = rx_new;
							nxt_r.rvalid = 1'b1;
						end
						if (r_ff.per == r_ff.total)
							nxt_r.state = HOST_TAIL;
						else
						begin
							if ((r_ff.per != '0) && (r_ff.per[2:0] == BIT_FIRST))
							begin
								src        = r_ff.read ? REG_RST : WDATA_I;
								nxt_r.take = ~r_ff.read;
							end
							// Input changes at the fall so it is steady all low phase
							nxt_r.serial_in = src[0];
							nxt_r.tx  = {1'b0, src[7:1]};
						end
					end
					else
					begin
						nxt_r.sclk = 1'b1;
						nxt_r.per  = r_ff.per + 7'h01;
					end
				end
				else
					nxt_r.div = r_ff.div + 1'b1;
			end
			HOST_TAIL:
			begin
				if (r_ff.div == DIV_END)
				begin
					nxt_r.div   = '0;
					nxt_r.cs_n  = 1'b1;
					nxt_r.sclk  = 1'b1;
					nxt_r.busy  = 1'b0;
					nxt_r.done  = 1'b1;
					nxt_r.state = HOST_IDLE;
				end
				else
					nxt_r.div = r_ff.div + 1'b1;
			end
			default:
				nxt_r.state = HOST_IDLE;
		endcase
	end

	always_ff @(posedge REF_CLK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
		begin
			r_ff      <= '0;
			r_ff.cs_n <= 1'b1;
			r_ff.sclk <= 1'b1;
		end
		else
			r_ff <= nxt_r;
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign PORT.cs_n     = r_ff.cs_n;
	assign PORT.sclk     = r_ff.sclk;
	assign PORT.serial_in      = r_ff.serial_in;
	assign WDATA_TAKE_O  = r_ff.take;
	assign RDATA_O       = r_ff.rdata;
	assign RDATA_VALID_O = r_ff.rvalid;
	assign BUSY_O        = r_ff.busy;
	assign DONE_O        = r_ff.done;
endmodule : lmp_host

/* File: testbench/lmp_port_props.sv */
// Concurrent checks on the serial port wires between host and device
`timescale 1ns/10ps
module lmp_port_props
	import lmp_pkg::*;
(
	// Clock and reset
	input  wire logic REF_CLK_I,
	input  wire logic RESET_N_I,
	// Port wires
	input  wire logic cs_n,
	input  wire logic sclk,
	input  wire logic serial_in,
	input  wire logic serial_out,
	input  wire logic sdo_oe
);
	// ------------------------------------------------------------
	// Frame tracking
	// ------------------------------------------------------------
	logic       sclk_q;
	logic [6:0] n_rise;
	logic [6:0] n_fall;
	logic [7:0] cmd;
	logic [2:0] since_fall;
	logic       burst_eff;

	assign burst_eff = cmd[CB_BURST] && (cmd[CB_ADDR_HI:CB_ADDR_LO] == 4'h0);

	// since_fall saturates so a long idle never aliases a fresh fall
	always_ff @(posedge REF_CLK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
		begin
			{sclk_q, n_rise, n_fall, cmd, since_fall} <= {1'b1, 25'h0};
		end
		else
		begin
			sclk_q     <= sclk;
			since_fall <= (!sclk && sclk_q) ? 3'h0 : since_fall + {2'h0, since_fall != 3'h7};
			n_rise     <= cs_n ? 7'h00 : n_rise + {6'h0, sclk && !sclk_q};
			n_fall     <= cs_n ? 7'h00 : n_fall + {6'h0, !sclk && sclk_q};
			if (!cs_n && sclk && !sclk_q && n_rise < 7'h08)
			begin
				cmd[n_rise[2:0]] <= serial_in;
			end
		end
	end

	default clocking cb @(posedge REF_CLK_I);
	endclocking
	default disable iff (!RESET_N_I);

	float_idle_a: assert property (cs_n [*6] |-> !sdo_oe)
		else $error("sdo driven while deselected");
	half_period_a: assert property ($changed(sclk) |=> $stable(sclk) [*3])
		else $error("sclk phase too short");
	sdi_on_fall_a: assert property (!cs_n && $changed(serial_in) |-> $fell(sclk))
		else $error("sdi moved outside sclk fall");
	sdo_on_fall_a: assert property (sdo_oe && $past(sdo_oe) && $changed(serial_out) |-> since_fall <= 3'h4)
		else $error("sdo moved away from sclk fall");
	reserved_zero_a: assert property (n_rise == 7'h08 |-> cmd[6:5] == CB_RESERVED)
		else $error("reserved command bits set");
	write_float_a: assert property (!cs_n && n_rise >= 7'h08 && !cmd[CB_RW] |-> !sdo_oe)
		else $error("sdo driven during write");
	read_drive_a: assert property ($fell(sclk) && n_fall == 7'h08 && cmd[CB_RW] |-> ##[2:5] sdo_oe)
		else $error("read data not driven");
	single_stop_a: assert property ($fell(sclk) && n_fall == 7'h10 && cmd[CB_RW] && !burst_eff
		|-> ##[2:5] !sdo_oe)
		else $error("single read ran past one byte");

	cover property ($fell(sclk) && n_fall == 7'h08 && cmd[CB_RW] && burst_eff);
	cover property (n_rise == 7'h10 && !cmd[CB_RW]);
	cover property (n_fall == 7'h58);
endmodule : lmp_port_props

/* File: testbench/testbench.sv */
// Self-checking bench joining the host and device ends of the serial port
`timescale 1ns/10ps
module testbench
	import lmp_pkg::*;
;
	logic       clk       = 1'b0;
	logic       rst_n     = 1'b0;
	logic       line_clk  = 1'b0;
	logic [9:0] ev        = 10'h0;
	logic       start     = 1'b0;
	logic       c_rd      = 1'b0;
	logic [3:0] c_addr    = 4'h0;
	logic       c_bm      = 1'b0;
	logic [3:0] c_cnt     = 4'h0;
	logic [7:0] wdata     = 8'h0;
	logic [7:0] st1c      = 8'h00;
	logic       take, rvalid, busy, done, alarm;
	logic [7:0] rdata, ctl1, ctl2;
	logic [7:0] wq [12];
	logic [7:0] rq [12];
	int         err_total = 0;
	int         n_tests   = 0;
	int         cyc       = 0;

	lmp_port_if u_lmp_port_if ();
	lmp_host u_lmp_host (.REF_CLK_I(clk), .RESET_N_I(rst_n), .PORT(u_lmp_port_if.host),
		.START_I(start), .CMD_READ_I(c_rd), .CMD_ADDR_I(c_addr), .CMD_BURST_I(c_bm),
		.BYTE_COUNT_I(c_cnt), .WDATA_I(wdata), .WDATA_TAKE_O(take), .RDATA_O(rdata),
		.RDATA_VALID_O(rvalid), .BUSY_O(busy), .DONE_O(done));
	// Event order: sync lost, viol, codeword, zero8, zero16, crc, oof, ft, fs, fps
	lmp_device u_lmp_device (.REF_CLK_I(clk), .RESET_N_I(rst_n), .PORT(u_lmp_port_if.device),
		.LINE_CLK_I(line_clk), .SYNC_LOST_I(ev[9]), .VIOL_I(ev[8]), .CODEWORD_I(ev[7]),
		.ZERO8_I(ev[6]), .ZERO16_I(ev[5]), .CRC_ERR_I(ev[4]), .OOF_EVENT_I(ev[3]),
		.FT_ERR_I(ev[2]), .FS_ERR_I(ev[1]), .FPS_ERR_I(ev[0]), .STATUS_ONE_COND_I(st1c),
		.STATUS_TWO_COND_I(8'h00), .ALARM_INT_O(alarm), .LINE_CONTROL_ONE_O(ctl1),
		.LINE_CONTROL_TWO_O(ctl2));
	lmp_port_props u_lmp_port_props (.REF_CLK_I(clk), .RESET_N_I(rst_n),
		.cs_n(u_lmp_port_if.cs_n), .sclk(u_lmp_port_if.sclk), .serial_in(u_lmp_port_if.serial_in),
		.serial_out(u_lmp_port_if.serial_out), .sdo_oe(u_lmp_port_if.sdo_oe));

	initial
	begin
		forever #4 clk = ~clk;
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
		n_tests++;
		if (s !== e)
		begin
			err_total++;
			$display("MISMATCH %s exp %h seen %h", nm, e, s);
		end
	endtask : chk

	task automatic print_verdict();
		if (err_total == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : print_verdict

	// Gap before start keeps chip select high long enough between frames
	task automatic xfer(input logic rw, input logic [3:0] a, input logic bm, input logic [3:0] n);
		int i;
		int k;
		i = 0;
		k = 0;
		repeat (4) @(posedge clk);
		{start, c_rd, c_addr, c_bm, c_cnt, wdata} <= {1'b1, rw, a, bm, n, wq[0]};
		@(posedge clk);
		start <= 1'b0;
		repeat (2000)
		begin
			@(negedge clk);
			if (take === 1'b1)
				i++;
			if (rvalid === 1'b1)
			begin
				rq[k] = rdata;
				k++;
			end
			if (done === 1'b1)
				break;
			@(posedge clk);
			wdata <= wq[i];
		end
		// A transfer that never finishes counts as a mismatch here
		chk("done", {7'h0, done}, 8'h01);
		chk("busy", {7'h0, busy}, 8'h00);
		chk("bytes", 8'(rw ? k : i), {4'h0, n});
	endtask : xfer

	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		wq[0] = v;
		xfer(1'b0, a, 1'b0, 4'h1);
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		xfer(1'b1, a, 1'b0, 4'h1);
		chk("reg", rq[0], e);
	endtask : rd

	// Line clock runs only here, so port traffic elsewhere sees it stopped
	task automatic ticks(input int n, input logic [9:0] e);
		@(posedge clk);
		ev <= e;
		repeat (n)
		begin
			repeat (5) @(posedge clk);
			line_clk <= 1'b1;
			repeat (5) @(posedge clk);
			line_clk <= 1'b0;
		end
		repeat (5) @(posedge clk);
		ev <= 10'h0;
		repeat (5) @(posedge clk);
	endtask : ticks

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_regs();
		for (int a = 2; a < 9; a++)
		begin
			wq[0] = {a[3:0], 4'h5};
			xfer(1'b0, a[3:0], a == 3, 4'h1);
			rd(a[3:0], (a == 5 || a == 7) ? 8'h00 : {a[3:0], 4'h5});
		end
	endtask : t_regs

	task automatic t_sat();
		wr(RA_CTL2, 8'h10);
		chk("ctl2", ctl2, 8'h10);
		wr(RA_VIOL_LO, 8'hfe);
		wr(RA_VIOL_HI, 8'hff);
		ticks(2, 10'h319);
		chk("alarm", {7'h0, alarm}, 8'h01);
		ticks(1, 10'h019);
	endtask : t_sat

	task automatic t_burst();
		logic [7:0] ex [11];
		ex = '{8'hff, 8'hff, 8'h26, 8'h36, 8'h46, 8'h00, 8'h65, 8'h01, 8'h85, 8'h00, 8'h10};
		xfer(1'b1, RA_VIOL_LO, 1'b1, 4'hb);
		for (int k = 0; k < 11; k++)
			chk("burst", rq[k], ex[k]);
		ticks(1, 10'h0);
		rd(RA_ST2, 8'h01);
		rd(RA_ST2, 8'h01);
		ticks(1, 10'h0);
		rd(RA_ST2, 8'h00);
		chk("alarm", {7'h0, alarm}, 8'h00);
		@(posedge clk);
		st1c <= 8'h04;
		ticks(1, 10'h0);
		chk("alarm", {7'h0, alarm}, 8'h01);
		rd(RA_ST1, 8'h04);
		ticks(1, 10'h0);
		rd(RA_ST1, 8'h04);
		@(posedge clk);
		st1c <= 8'h00;
		ticks(1, 10'h0);
		rd(RA_ST1, 8'h00);
	endtask : t_burst

	task automatic t_auto();
		rd(RA_CRC, 8'h26);
		wr(RA_CTL1, 8'h10);
		chk("ctl1", ctl1, 8'h10);
		rd(RA_OOF, 8'h36);
		ticks(1, 10'h0);
		xfer(1'b1, RA_VIOL_LO, 1'b1, 4'h5);
		for (int k = 0; k < 5; k++)
			chk("cleared", rq[k], 8'h00);
	endtask : t_auto

	task automatic t_modes();
		wr(RA_CTL1, 8'h00);
		wr(RA_CRC, 8'h07);
		wr(RA_CTL2, 8'h24);
		ticks(2, 10'h056);
		rd(RA_CRC, 8'h00);
		rd(RA_FE, 8'h02);
		rd(RA_VIOL_LO, 8'h02);
		wr(RA_CTL1, 8'h08);
		ticks(1, 10'h002);
		rd(RA_FE, 8'h03);
		wq[0] = 8'h34;
		wq[1] = 8'h12;
		xfer(1'b0, RA_VIOL_LO, 1'b1, 4'h2);
		rd(RA_VIOL_HI, 8'h12);
		rd(RA_VIOL_LO, 8'h34);
	endtask : t_modes

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			err_total++;
			print_verdict();
		end
	end

	initial
	begin
		foreach (wq[j])
			wq[j] = 8'h00;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_sat();
		t_burst();
		t_auto();
		t_modes();
		print_verdict();
	end
endmodule : testbench
